/* rtl/crmu_control_move.sv */
// Control register move unit: executes the control move between the
// control registers and any other register, memory word or immediate.
// Assumes an instruction decoder presents one request per instruction.
//
// Function
// - Y address decoded from five-bit field.
// - X mode bits select update, low bits register.
// - Y register always in opposite bank.
// - Modifier and controller registers form control set.
// - Any memory mode or immediate is accepted.
// - Stack high read post-decrements stack pointer.
// - Stack high write pre-increments stack pointer.
// - Accumulator source shifted by scaling bits.
// - Extension in use stores saturation constant.
// - Sixteen-bit target keeps low saturated bits.
// - Accumulator parts are never limited.
// - Limiting sets sticky flag unless status written.
// - Accumulator target sign-extends, zero-fills low word.
// - Sixteen-bit source zero-padded into 24 bits.
// - Sixteen-bit source to accumulator via middle word.
// - Middle word target written without extension.
// - New modifier unusable by the next instruction.
// - Status write loads flags from source bits.
`timescale 1ns/1ps
`default_nettype none

module crmu_control_move
   import crmu_pkg::*;
#(
   parameter int SP_W = 4
)
(
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire crmu_req_t           req,
   input  wire logic                xy_valid,
   input  wire logic [5:0]          x_field,
   input  wire logic [4:0]          y_field,
   output var  crmu_res_t           result,
   output logic [15:0]              status_word,
   output logic [15:0]              operating_mode_word,
   output logic [15:0]              loop_end_address,
   output logic [15:0]              loop_count,
   output logic [SP_W-1:0]          stack_ptr,
   output logic [7:0][15:0]         mod_view,
   output var  crmu_ea_t            x_ea,
   output var  crmu_ea_t            y_ea
);

   localparam int DEPTH = 1 << SP_W;

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------

   logic [15:0]      status_word_reg;
   logic [15:0]      opmode_reg;
   logic [15:0]      loop_end_reg;
   logic [15:0]      loop_cnt_reg;
   logic [SP_W-1:0]  stack_ptr_reg;
   logic [SP_W-1:0]  sp_inc;
   logic [15:0]      stack_hi [DEPTH];
   logic [15:0]      stack_lo [DEPTH];
   logic [7:0][15:0] mod_file_reg;
   logic [7:0][15:0] mod_view_reg;
   crmu_res_t        result_reg;
   crmu_res_t        result_next;
   crmu_ea_t         x_ea_reg;
   crmu_ea_t         y_ea_reg;
   crmu_ea_t         x_ea_next;
   crmu_ea_t         y_ea_next;
   logic             do_rd;
   logic             do_wr;
   logic [15:0]      ctrl_rd_val;
   logic [15:0]      ctrl_wr_val;
   crmu_lim_t        lim;

   // -------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------

   // Modifier registers share one selector prefix.
   function automatic logic sel_is_mod(input logic [4:0] sel);
      sel_is_mod = (sel[4:3] == `CRMU_SEL_MREG);
   endfunction

   // Shift an accumulator by the scaling mode, then limit it to 24 bits
   // when the extension holds more than sign copies.
   function automatic crmu_lim_t scale_limit(input logic [55:0] acc,
                                             input logic [1:0]  sc);
      logic [55:0] sh;
      crmu_lim_t   r;
      sh = acc;
      r  = '0;
      case (sc)
         `CRMU_SC_DOWN: sh = {acc[55], acc[55:1]};
         `CRMU_SC_UP:   sh = {acc[54:0], 1'b0};
         default:       sh = acc;
      endcase
      r.hit = (sh[`CRMU_EXT_MSB:`CRMU_EXT_LSB] != '0) &&
              (sh[`CRMU_EXT_MSB:`CRMU_EXT_LSB] != '1);
      if (r.hit)
      begin
         r.val = sh[55] ? `CRMU_SAT_NEG : `CRMU_SAT_POS;
      end
      else
      begin
         r.val = sh[47:24];
      end
      scale_limit = r;
   endfunction

   // Place a 16-bit control value into the other side's format.
   function automatic logic [55:0] widen16(input logic [15:0] v,
                                           input crmu_kind_t  k);
      logic [23:0] w;
      w = {8'h00, v};
      case (k)
         kind_acc: widen16 = {{8{w[23]}}, w, 24'h000000};
         kind_mid: widen16 = {32'h00000000, w};
         kind_r16: widen16 = {40'h0000000000, v};
         default:  widen16 = {32'h00000000, w};
      endcase
   endfunction

   // -------------------------------------------------------------
   // Request decode
   // -------------------------------------------------------------

   // Any source mode reaches here as plain data, so memory, register
   // and immediate operands all take the same path.
   assign do_rd  = req.valid && !req.to_ctrl;
   assign do_wr  = req.valid && req.to_ctrl;
   assign sp_inc = SP_W'(stack_ptr_reg + 1'b1);
   assign lim    = scale_limit(req.data,
                     status_word_reg[`CRMU_SW_SC_MSB:`CRMU_SW_SC_LSB]);

   // Read side of the control register set.
   always_comb
   begin
      ctrl_rd_val = '0;
      if (sel_is_mod(req.ctrl_sel))
      begin
         ctrl_rd_val = mod_file_reg[req.ctrl_sel[2:0]];
      end
      else
      begin
         case (req.ctrl_sel)
            `CRMU_SEL_STATUS: ctrl_rd_val = status_word_reg;
            `CRMU_SEL_OPMODE: ctrl_rd_val = opmode_reg;
            `CRMU_SEL_STKPTR: ctrl_rd_val = 16'(stack_ptr_reg);
            `CRMU_SEL_STKHI:  ctrl_rd_val = stack_hi[stack_ptr_reg];
            `CRMU_SEL_STKLO:  ctrl_rd_val = stack_lo[stack_ptr_reg];
            `CRMU_SEL_LPEND:  ctrl_rd_val = loop_end_reg;
            `CRMU_SEL_LPCNT:  ctrl_rd_val = loop_cnt_reg;
            default:       ctrl_rd_val = '0;
         endcase
      end
   end

   // Write data: only a full accumulator is limited; its parts and
   // every other source pass their low 16 bits untouched.
   always_comb
   begin
      case (req.kind)
         kind_acc: ctrl_wr_val = lim.val[15:0];
         default:  ctrl_wr_val = req.data[15:0];
      endcase
   end

   // -------------------------------------------------------------
   // Status word
   // -------------------------------------------------------------

   // A status write wins outright; otherwise limiting latches the
   // sticky flag, which only a status write can clear.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status_word_reg <= `CRMU_SW_RST;
      end
      else if (do_wr && req.ctrl_sel == `CRMU_SEL_STATUS)
      begin
         status_word_reg <= ctrl_wr_val;
      end
      else if (do_wr && req.kind == kind_acc && lim.hit)
      begin
         status_word_reg[`CRMU_SW_LIM_BIT] <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // System stack
   // -------------------------------------------------------------

   // Reading the high word pops after the read; writing it pushes
   // first. The program keeps the high-to-high move out of the stream.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stack_ptr_reg <= '0;
      end
      else if (do_wr && req.ctrl_sel == `CRMU_SEL_STKPTR)
      begin
         stack_ptr_reg <= ctrl_wr_val[SP_W-1:0];
      end
      else if (do_wr && req.ctrl_sel == `CRMU_SEL_STKHI)
      begin
         stack_ptr_reg <= sp_inc;
      end
      else if (do_rd && req.ctrl_sel == `CRMU_SEL_STKHI)
      begin
         stack_ptr_reg <= SP_W'(stack_ptr_reg - 1'b1);
      end
   end

   // Stack words are plain storage and carry no reset.
   always_ff @(posedge clk)
   begin
      if (do_wr && req.ctrl_sel == `CRMU_SEL_STKHI)
      begin
         stack_hi[sp_inc] <= ctrl_wr_val;
      end
      if (do_wr && req.ctrl_sel == `CRMU_SEL_STKLO)
      begin
         stack_lo[stack_ptr_reg] <= ctrl_wr_val;
      end
   end

   // -------------------------------------------------------------
   // Loop and mode registers
   // -------------------------------------------------------------

   // The program keeps restricted moves away from loop ends and flow
   // changes, so no interlock is built here.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         loop_end_reg <= `CRMU_CTRL_RST;
         loop_cnt_reg <= `CRMU_CTRL_RST;
         opmode_reg   <= `CRMU_CTRL_RST;
      end
      else if (do_wr)
      begin
         case (req.ctrl_sel)
            `CRMU_SEL_LPEND:  loop_end_reg <= ctrl_wr_val;
            `CRMU_SEL_LPCNT:  loop_cnt_reg <= ctrl_wr_val;
            `CRMU_SEL_OPMODE: opmode_reg   <= ctrl_wr_val;
            default:          opmode_reg   <= opmode_reg;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Modifier registers
   // -------------------------------------------------------------

   // The file takes the write at once.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mod_file_reg <= '0;
      end
      else if (do_wr && sel_is_mod(req.ctrl_sel))
      begin
         mod_file_reg[req.ctrl_sel[2:0]] <= ctrl_wr_val;
      end
   end

   // The address unit sees a copy refreshed per instruction from the
   // file as it stood before that instruction, so a new value shows
   // one instruction late; this avoids a bypass path.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mod_view_reg <= '0;
      end
      else if (req.valid)
      begin
         mod_view_reg <= mod_file_reg;
      end
   end

   // -------------------------------------------------------------
   // Result towards the other operand
   // -------------------------------------------------------------

   always_comb
   begin
      result_next.valid = do_rd;
      result_next.data  = widen16(ctrl_rd_val, req.kind);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         result_reg <= '0;
      end
      else
      begin
         result_reg <= result_next;
      end
   end

   // -------------------------------------------------------------
   // Dual move address decode
   // -------------------------------------------------------------

   crmu_xy_decode u_xy_decode
   (
      .x_field (x_field),
      .y_field (y_field),
      .x_ea    (x_ea_next),
      .y_ea    (y_ea_next)
   );

   // Decoded addresses are held until the next dual move.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         x_ea_reg <= '0;
         y_ea_reg <= '0;
      end
      else if (xy_valid)
      begin
         x_ea_reg <= x_ea_next;
         y_ea_reg <= y_ea_next;
      end
   end

   // Outputs come straight from the registers above.
   assign result              = result_reg;
   assign status_word         = status_word_reg;
   assign operating_mode_word = opmode_reg;
   assign loop_end_address    = loop_end_reg;
   assign loop_count          = loop_cnt_reg;
   assign stack_ptr           = stack_ptr_reg;
   assign mod_view            = mod_view_reg;
   assign x_ea                = x_ea_reg;
   assign y_ea                = y_ea_reg;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_stkhi_read_pop: assert property (
      do_rd && req.ctrl_sel == `CRMU_SEL_STKHI
      |=> stack_ptr_reg == SP_W'($past(stack_ptr_reg) - 1'b1))
      else $error("Stack pointer not decremented after high read.");

   a_stkhi_write_push: assert property (
      do_wr && req.ctrl_sel == `CRMU_SEL_STKHI
      |=> stack_ptr_reg == SP_W'($past(stack_ptr_reg) + 1'b1)
          && stack_hi[stack_ptr_reg] == $past(ctrl_wr_val))
      else $error("Stack high word not pushed.");

   // A full accumulator source is limited first, so only plain sources
   // must show their raw bits in the flags.
   a_sw_flag_load: assert property (
      do_wr && req.ctrl_sel == `CRMU_SEL_STATUS && req.kind != kind_acc
      |=> status_word_reg[`CRMU_SW_FLAG_MSB:0] == $past(req.data[6:0]))
      else $error("Status flags not loaded from source.");

   a_limit_flag_set: assert property (
      do_wr && req.kind == kind_acc && req.ctrl_sel != `CRMU_SEL_STATUS
      && (req.data[55:47] != '0) && (req.data[55:47] != '1)
      && status_word_reg[`CRMU_SW_SC_MSB:`CRMU_SW_SC_LSB] == `CRMU_SC_NONE
      |=> status_word_reg[`CRMU_SW_LIM_BIT])
      else $error("Limit flag not set.");

   a_sat_low_bits: assert property (
      do_wr && req.kind == kind_acc && req.ctrl_sel == `CRMU_SEL_LPEND
      && (req.data[55:47] != '0) && (req.data[55:47] != '1)
      && status_word_reg[`CRMU_SW_SC_MSB:`CRMU_SW_SC_LSB] == `CRMU_SC_NONE
      |=> loop_end_reg == ($past(req.data[55]) ? 16'h0000 : 16'hffff))
      else $error("Saturated low bits not stored.");

   a_part_unlimited: assert property (
      do_wr && req.kind == kind_mid && req.ctrl_sel == `CRMU_SEL_LPCNT
      |=> loop_cnt_reg == $past(req.data[15:0]) && $stable(status_word_reg))
      else $error("Accumulator part was limited.");

   a_pad_upper_zero: assert property (
      do_rd && req.kind == kind_r24
      |=> result_reg.valid && result_reg.data[23:16] == 8'h00)
      else $error("Upper byte not cleared.");

   a_acc_fill: assert property (
      do_rd && req.kind == kind_acc
      |=> result_reg.data[23:0] == 24'h000000
          && result_reg.data[55:48] == {8{result_reg.data[47]}}
          && result_reg.data[39:24] == $past(ctrl_rd_val))
      else $error("Accumulator fill wrong.");

   a_mod_one_late: assert property (
      do_wr && sel_is_mod(req.ctrl_sel)
      |=> mod_view_reg == $past(mod_file_reg)
          && mod_file_reg[$past(req.ctrl_sel[2:0])] == $past(ctrl_wr_val))
      else $error("Modifier visible too early.");

   a_y_bank_swap: assert property (
      xy_valid |=> y_ea_reg.reg_idx[2] != x_ea_reg.reg_idx[2]
                   && y_ea_reg.reg_idx[1:0] == $past(y_field[1:0]))
      else $error("Y register not in opposite bank.");

   a_x_mode_dec: assert property (
      xy_valid && x_field[4:3] == `CRMU_EA_DEC
      |=> x_ea_reg.mode == ea_post_dec)
      else $error("X post-decrement mode not decoded.");

endmodule

`default_nettype wire

/* rtl/crmu_consts.svh */
// Constants of the control register move unit: selector codes,
// status word fields, saturation values and reset values.
// Assumes it is included by the crmu package only.
`ifndef CRMU_CONSTS_SVH
`define CRMU_CONSTS_SVH

// Control register selector codes of the five-bit field.
`define CRMU_SEL_STATUS 5'h19
`define CRMU_SEL_OPMODE 5'h1a
`define CRMU_SEL_STKPTR 5'h1b
`define CRMU_SEL_STKHI  5'h1c
`define CRMU_SEL_STKLO  5'h1d
`define CRMU_SEL_LPEND  5'h1e
`define CRMU_SEL_LPCNT  5'h1f
`define CRMU_SEL_MREG   2'h0

// Status word fields.
`define CRMU_SW_LIM_BIT  6
`define CRMU_SW_FLAG_MSB 6
`define CRMU_SW_SC_MSB   11
`define CRMU_SW_SC_LSB   10

// Scaling modes of the two scaling bits.
`define CRMU_SC_NONE 2'h0
`define CRMU_SC_DOWN 2'h1
`define CRMU_SC_UP   2'h2

// Accumulator limiting.
`define CRMU_EXT_MSB 55
`define CRMU_EXT_LSB 47
`define CRMU_SAT_POS 24'h7fffff
`define CRMU_SAT_NEG 24'h800000

// Effective address update modes.
`define CRMU_EA_NOUPD 2'h0
`define CRMU_EA_OFFS  2'h1
`define CRMU_EA_DEC   2'h2
`define CRMU_EA_INC   2'h3

// Reset values.
`define CRMU_SW_RST   16'h0000
`define CRMU_CTRL_RST 16'h0000

`endif

/* rtl/crmu_pkg.sv */
// Types shared by the control register move unit.
// Assumes crmu_consts.svh is on the include path.
package crmu_pkg;
`include "crmu_consts.svh"

   // Update mode of a dual move effective address.
   typedef enum logic [1:0]
   {
      ea_no_update = `CRMU_EA_NOUPD,
      ea_offset    = `CRMU_EA_OFFS,
      ea_post_dec  = `CRMU_EA_DEC,
      ea_post_inc  = `CRMU_EA_INC
   } crmu_ea_mode_t;

   // Kind of the non-control side of a control move.
   typedef enum logic [1:0]
   {
      kind_r24,
      kind_r16,
      kind_acc,
      kind_mid
   } crmu_kind_t;

   typedef struct packed
   {
      logic        valid;
      logic        to_ctrl;
      logic [4:0]  ctrl_sel;
      crmu_kind_t  kind;
      logic [55:0] data;
   } crmu_req_t;

   typedef struct packed
   {
      logic        valid;
      logic [55:0] data;
   } crmu_res_t;

   typedef struct packed
   {
      crmu_ea_mode_t mode;
      logic [2:0]    reg_idx;
      logic          write;
   } crmu_ea_t;

   typedef struct packed
   {
      logic        hit;
      logic [23:0] val;
   } crmu_lim_t;

endpackage

/* rtl/crmu_xy_decode.sv */
// Field decoder of the dual X/Y parallel move addresses.
// Purely combinational; the caller registers the outputs.
`timescale 1ns/1ps
`default_nettype none

module crmu_xy_decode
   import crmu_pkg::*;
(
   input  wire logic [5:0] x_field,
   input  wire logic [4:0] y_field,
   output var  crmu_ea_t   x_ea,
   output var  crmu_ea_t   y_ea
);

   // The Y side reuses the two low bits but always lands in the
   // bank opposite to the X side, so the two addresses never clash.
   always_comb
   begin
      x_ea.write   = x_field[5];
      x_ea.mode    = crmu_ea_mode_t'(x_field[4:3]);
      x_ea.reg_idx = x_field[2:0];
      y_ea.write   = y_field[4];
      y_ea.mode    = crmu_ea_mode_t'(y_field[3:2]);
      y_ea.reg_idx = {~x_field[2], y_field[1:0]};
   end

endmodule

`default_nettype wire

/* testbench/test_control_register_move_unit.sv */
// Self-checking testbench of the control register move unit.
// Assumes the design files under rtl/ are compiled first and that the
// design asserts its own rules; the bench drives the ports directly.
`timescale 1ns/1ps
`default_nettype none

module test_control_register_move_unit
   import crmu_pkg::*;
();
   // ----------------------------------------------------------------
   // Signals and selector codes
   // ----------------------------------------------------------------
   localparam logic [4:0] SEL_STATUS = 5'h19;
   localparam logic [4:0] SEL_OPMODE = 5'h1a;
   localparam logic [4:0] SEL_STKPTR = 5'h1b;
   localparam logic [4:0] SEL_STKHI  = 5'h1c;
   localparam logic [4:0] SEL_STKLO  = 5'h1d;
   localparam logic [4:0] SEL_LPEND  = 5'h1e;
   localparam logic [4:0] SEL_LPCNT  = 5'h1f;

   logic             clk;
   logic             reset_n;
   crmu_req_t        req;
   logic             xy_valid;
   logic [5:0]       x_field;
   logic [4:0]       y_field;
   crmu_res_t        result;
   logic [15:0]      status_word;
   logic [15:0]      operating_mode_word;
   logic [15:0]      loop_end_address;
   logic [15:0]      loop_count;
   logic [3:0]       stack_ptr;
   logic [7:0][15:0] mod_view;
   crmu_ea_t         x_ea;
   crmu_ea_t         y_ea;
   int               err_total;
   int               num_checks;
   logic [31:0]      rnd;
   logic [15:0]      mval [8];

   crmu_control_move #(.SP_W(4)) u_dut
   (
      .clk                 (clk),
      .reset_n             (reset_n),
      .req                 (req),
      .xy_valid            (xy_valid),
      .x_field             (x_field),
      .y_field             (y_field),
      .result              (result),
      .status_word         (status_word),
      .operating_mode_word (operating_mode_word),
      .loop_end_address    (loop_end_address),
      .loop_count          (loop_count),
      .stack_ptr           (stack_ptr),
      .mod_view            (mod_view),
      .x_ea                (x_ea),
      .y_ea                (y_ea)
   );

   // Free-running clock at 200 MHz.
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Random source: a fixed-seed shift register keeps runs repeatable.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected result of a control read for each kind of target.
   function automatic logic [55:0] conv(input crmu_kind_t k, input logic [15:0] v);
      if (k == kind_acc)
         return {16'h0000, v, 24'h000000};
      return {40'h0000000000, v};
   endfunction

   // Limit flag and stored 16-bit value for an accumulator source.
   function automatic logic [16:0] lim_exp(input logic [55:0] d, input logic [1:0] sc);
      logic [55:0] s;
      s = (sc == 2'h1) ? {d[55], d[55:1]} : (sc == 2'h2) ? {d[54:0], 1'b0} : d;
      if (s[55:47] == {9{s[55]}})
         return {1'b0, s[39:24]};
      return {1'b1, s[55] ? 16'h0000 : 16'hffff};
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One request per call; valid stays up so calls may run back to back.
   task automatic move(input logic to_c, input logic [4:0] sel, input crmu_kind_t k,
                       input logic [55:0] d);
      req = '{valid: 1'b1, to_ctrl: to_c, ctrl_sel: sel, kind: k, data: d};
      @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [4:0] sel, input crmu_kind_t k, input logic [55:0] exp);
      move(1'b0, sel, k, 56'h0);
      chk(result.valid, 1'b1);
      chk(result.data, exp);
   endtask

   task automatic idle();
      req.valid = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles.
   initial
   begin
      #20000;
      err_total++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [55:0] d;
      logic [16:0] e;
      logic [1:0]  sc;
      err_total = 0;
      num_checks = 0;
      rnd = 32'h1221;
      reset_n = 1'b0;
      req = '0;
      xy_valid = 1'b0;
      x_field = 6'h00;
      y_field = 5'h00;
      repeat (8) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk({status_word, operating_mode_word, loop_end_address, loop_count}, 64'h0);
      chk({stack_ptr, result}, 64'h0);
      chk(mod_view[3:0], 64'h0);
      chk(mod_view[7:4], 64'h0);

      // Modifier, mode and loop registers written and read back through a 24-bit target.
      for (int i = 0; i < 11; i++)
      begin
         logic [4:0] sel;
         sel = (i < 8) ? 5'(i) : (i == 8) ? SEL_OPMODE : (i == 9) ? SEL_LPEND : SEL_LPCNT;
         rnd = lfsr_next(rnd);
         if (i < 8)
            mval[i] = rnd[15:0];
         move(1'b1, sel, kind_r24, {32'h0, rnd[23:0]});
         if (i == 8)
            chk(operating_mode_word, rnd[15:0]);
         rd(sel, kind_r24, {40'h0, rnd[15:0]});
      end
      for (int k = 0; k < 4; k++)
         rd(SEL_LPCNT, crmu_kind_t'(k), conv(crmu_kind_t'(k), rnd[15:0]));
      rd(5'h10, kind_r24, 56'h0);

      // Stack pointer write, two pushes, two pops, then the low word.
      move(1'b1, SEL_STKPTR, kind_r24, 56'h00001a);
      chk(stack_ptr, 4'ha);
      move(1'b1, SEL_STKHI, kind_r24, 56'h00beef);
      chk(stack_ptr, 4'hb);
      move(1'b1, SEL_STKHI, kind_r24, 56'h001357);
      chk(stack_ptr, 4'hc);
      rd(SEL_STKHI, kind_r24, 56'h001357);
      chk(stack_ptr, 4'hb);
      rd(SEL_STKHI, kind_r24, 56'h00beef);
      chk(stack_ptr, 4'ha);
      rd(SEL_STKPTR, kind_r24, 56'h00000a);
      move(1'b1, SEL_STKLO, kind_r24, 56'h002468);
      rd(SEL_STKLO, kind_r24, 56'h002468);

      // A new modifier is hidden from the very next instruction.
      move(1'b1, 5'h05, kind_r24, 56'h005a5a);
      chk(mod_view[5], mval[5]);
      move(1'b0, SEL_LPCNT, kind_r24, 56'h0);
      chk(mod_view[5], 16'h5a5a);

      // Accumulator source under every scaling mode, with and without limiting.
      for (int i = 0; i < 12; i++)
      begin
         sc = i[1:0];
         rnd = lfsr_next(rnd);
         case (i)
            0: d = 56'h00123456000000;
            1: d = 56'h01000000000000;
            2: d = 56'hff000000000000;
            3: d = 56'h00400000000000;
            default: d = {{24{rnd[31]}}, rnd} << (i * 3);
         endcase
         e = lim_exp(d, sc);
         move(1'b1, SEL_STATUS, kind_r24, {40'h0, 4'h0, sc, 10'h000});
         move(1'b1, SEL_LPEND, kind_acc, d);
         chk(loop_end_address, e[15:0]);
         chk(status_word, {4'h0, sc, 3'h0, e[16], 6'h00});
      end

      // An accumulator part is never limited, even with a wide value.
      move(1'b1, SEL_STATUS, kind_r24, 56'h0);
      move(1'b1, SEL_LPCNT, kind_mid, 56'hffffffff001234);
      chk(loop_count, 16'h1234);
      chk(status_word, 16'h0000);

      // Status word written directly takes its flags from the source bits.
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr_next(rnd);
         move(1'b1, SEL_STATUS, kind_r24, {32'h0, rnd[23:0]});
         chk(status_word[6:0], rnd[6:0]);
      end
      idle();

      // Dual move decode, every X update mode in turn.
      for (int i = 0; i < 16; i++)
      begin
         rnd = lfsr_next(rnd);
         x_field = {rnd[5], i[1:0], rnd[2:0]};
         y_field = rnd[10:6];
         xy_valid = 1'b1;
         @(posedge clk);
         #1;
         chk({x_ea, y_ea}, {x_field[4:3], x_field[2:0], x_field[5],
             y_field[3:2], ~x_field[2], y_field[1:0], y_field[4]});
      end
      xy_valid = 1'b0;
      final_report();
   end
endmodule
`default_nettype wire
